// ### src/oag_core.sv
/*
 Operand address generator of an 8-bit core: fetches operand bytes after
 the opcode, reads page-zero pointers and forms the effective address.
 Assumes the opcode decoder supplies mode, index and the address of the
 first operand byte; fetch and data memory answer one cycle after a request.
*/
`timescale 1ns/1ps
module oag_core
	import oag_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         start,
	input  wire oag_mode_type mode,
	input  wire logic         rmw_op,
	input  wire logic [7:0]   index_value,
	input  wire logic [2:0]   bit_select,
	input  wire logic [15:0]  operand_pc,
	output logic              prog_req,
	output logic [15:0]       prog_addr,
	input  wire logic [7:0]   prog_data,
	output logic              data_req,
	output logic [15:0]       data_addr,
	input  wire logic [7:0]   data_data,
	output logic              busy,
	output logic              done,
	output logic              illegal_mode,
	output logic [15:0]       ea_reg,
	output logic [7:0]        imm_reg,
	output logic [2:0]        bit_pos_reg,
	output logic [15:0]       branch_target_reg,
	output logic [15:0]       next_pc_reg,
	output logic [1:0]        extra_bytes_reg
);

	oag_state_type state_reg;
	oag_state_type state_next;
	oag_mode_type  mode_reg;
	logic [1:0]    need_bytes;
	logic          need_ptr;
	logic          need_word;
	logic          short_form;
	logic [1:0]    fetched_reg;
	logic [1:0]    total_reg;
	logic [15:0]   fetch_pc_reg;
	logic [7:0]    op0_reg;
	logic [7:0]    op1_reg;
	logic [7:0]    ptr_lo_reg;
	logic [7:0]    index_reg;
	logic          word_reg;
	logic          ptr_reg;
	logic          pend_fetch_reg;
	logic          pend_ptr_reg;
	logic [15:0]   base_addr;
	logic [15:0]   ea_next;
	logic [7:0]    disp;
	logic [15:0]   after_pc;
	oag_mode_type  cur_mode;
	logic [7:0]    cur_index;
	logic [7:0]    cur_op0;
	logic [7:0]    cur_op1;
	logic [7:0]    cur_ptr;

	oag_mode_table u_table (
		.mode          (start ? mode : mode_reg),
		.operand_bytes (need_bytes),
		.uses_pointer  (need_ptr),
		.word_pointer  (need_word),
		.is_short_form (short_form)
	);

	// Modify ops only exist in short form; refuse a long one
	assign illegal_mode = start && rmw_op && !short_form;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			OAG_ST_IDLE: begin
				if (start && !illegal_mode) begin
					state_next = (need_bytes == 2'd0) ? OAG_ST_DONE : OAG_ST_FETCH;
				end
			end
			OAG_ST_FETCH: begin
				if (pend_fetch_reg && fetched_reg + 2'd1 == total_reg) begin
					state_next = ptr_reg ? OAG_ST_PTR_LO : OAG_ST_DONE;
				end
			end
			OAG_ST_PTR_LO: begin
				if (pend_ptr_reg) begin
					state_next = word_reg ? OAG_ST_PTR_HI : OAG_ST_DONE;
				end
			end
			OAG_ST_PTR_HI: begin
				if (pend_ptr_reg) begin
					state_next = OAG_ST_DONE;
				end
			end
			OAG_ST_DONE: begin
				state_next = OAG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= OAG_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Latch the request context
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_reg     <= OAG_INHERENT;
			index_reg    <= OAG_BYTE_RESET;
			bit_pos_reg  <= 3'd0;
			total_reg    <= 2'd0;
			word_reg     <= 1'b0;
			ptr_reg      <= 1'b0;
		end else if (state_reg == OAG_ST_IDLE && start && !illegal_mode) begin
			mode_reg     <= mode;
			index_reg    <= index_value;
			bit_pos_reg  <= bit_select;
			total_reg    <= need_bytes;
			word_reg     <= need_word;
			ptr_reg      <= need_ptr;
		end
	end

	// Operand byte fetch; one byte per two cycles, request then capture
	assign prog_req  = (state_reg == OAG_ST_FETCH) && !pend_fetch_reg;
	assign prog_addr = fetch_pc_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fetch_pc_reg   <= OAG_ADDR_RESET;
			fetched_reg    <= 2'd0;
			pend_fetch_reg <= 1'b0;
			op0_reg        <= OAG_BYTE_RESET;
			op1_reg        <= OAG_BYTE_RESET;
		end else if (state_reg == OAG_ST_IDLE && start) begin
			fetch_pc_reg   <= operand_pc;
			fetched_reg    <= 2'd0;
			pend_fetch_reg <= 1'b0;
		end else if (prog_req) begin
			pend_fetch_reg <= 1'b1;
		end else if (pend_fetch_reg) begin
			pend_fetch_reg <= 1'b0;
			fetch_pc_reg   <= fetch_pc_reg + 16'h0001;
			fetched_reg    <= fetched_reg + 2'd1;
			if (fetched_reg == 2'd0) begin
				op0_reg <= prog_data;
			end else begin
				op1_reg <= prog_data;
			end
		end
	end

	// Pointers always sit in page zero
	assign data_req  = (state_reg == OAG_ST_PTR_LO || state_reg == OAG_ST_PTR_HI) && !pend_ptr_reg;
	assign data_addr = {OAG_PAGE_ZERO_HI, op0_reg + ((state_reg == OAG_ST_PTR_HI) ? 8'h01 : 8'h00)};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pend_ptr_reg <= 1'b0;
			ptr_lo_reg   <= OAG_BYTE_RESET;
		end else if (data_req) begin
			pend_ptr_reg <= 1'b1;
		end else if (pend_ptr_reg) begin
			pend_ptr_reg <= 1'b0;
			if (state_reg == OAG_ST_PTR_LO) begin
				ptr_lo_reg <= data_data;
			end
		end
	end

	// Word pointer stored high byte first; low byte at pointer plus one
	// Bytes landing on the edge into done are forwarded, else results lag one request
	always_comb begin
		cur_mode  = (state_reg == OAG_ST_IDLE) ? mode : mode_reg;
		cur_index = (state_reg == OAG_ST_IDLE) ? index_value : index_reg;
		cur_op0   = (pend_fetch_reg && fetched_reg == 2'd0) ? prog_data : op0_reg;
		cur_op1   = (pend_fetch_reg && fetched_reg == 2'd1) ? prog_data : op1_reg;
		cur_ptr   = (pend_ptr_reg && state_reg == OAG_ST_PTR_LO) ? data_data : ptr_lo_reg;
		base_addr = {OAG_PAGE_ZERO_HI, cur_op0};
		disp      = cur_op0;
		unique case (cur_mode)
			OAG_LONG_DIRECT, OAG_IDX_LONG: base_addr = {cur_op0, cur_op1};
			OAG_IND_SHORT, OAG_IND_IDX_SHORT, OAG_BIT_INDIRECT, OAG_BIT_INDIRECT_REL: begin
				base_addr = {OAG_PAGE_ZERO_HI, cur_ptr};
			end
			OAG_IND_LONG, OAG_IND_IDX_LONG: base_addr = {ptr_lo_reg, data_data};
			OAG_IDX_NO_OFS: base_addr = OAG_ADDR_RESET;
			default: base_addr = {OAG_PAGE_ZERO_HI, cur_op0};
		endcase
		if (cur_mode == OAG_REL_INDIRECT) begin
			disp = cur_ptr;
		end else if (cur_mode == OAG_BIT_DIRECT_REL || cur_mode == OAG_BIT_INDIRECT_REL) begin
			disp = cur_op1;
		end
		ea_next = base_addr;
		unique case (cur_mode)
			OAG_IDX_NO_OFS, OAG_IDX_SHORT, OAG_IDX_LONG, OAG_IND_IDX_SHORT, OAG_IND_IDX_LONG: begin
				ea_next = base_addr + {8'h00, cur_index};
			end
			default: ea_next = base_addr;
		endcase
	end

	assign after_pc = operand_pc + {14'h0000, need_bytes};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ea_reg            <= OAG_ADDR_RESET;
			imm_reg           <= OAG_BYTE_RESET;
			branch_target_reg <= OAG_ADDR_RESET;
			next_pc_reg       <= OAG_ADDR_RESET;
			extra_bytes_reg   <= 2'd0;
		end else begin
			if (state_reg == OAG_ST_IDLE && start && !illegal_mode) begin
				next_pc_reg     <= after_pc;
				// Pointer read counts as one more byte of the instruction
				extra_bytes_reg <= need_bytes + (need_ptr ? 2'd1 : 2'd0);
			end
			if (state_next == OAG_ST_DONE && state_reg != OAG_ST_DONE) begin
				ea_reg            <= ea_next;
				imm_reg           <= cur_op0;
				branch_target_reg <= next_pc_reg + {{8{disp[7]}}, disp};
			end
		end
	end

	assign busy = (state_reg != OAG_ST_IDLE);
	assign done = (state_reg == OAG_ST_DONE);

	property p_rmw_short;
		@(posedge sys_clk) disable iff (sys_rst)
		(start && rmw_op && !short_form) |=> (state_reg == OAG_ST_IDLE);
	endproperty
	a_rmw_short: assert property (p_rmw_short) else $error("long form accepted for modify op");

	property p_page_zero_ptr;
		@(posedge sys_clk) disable iff (sys_rst)
		data_req |-> (data_addr[15:8] == 8'h00);
	endproperty
	a_page_zero_ptr: assert property (p_page_zero_ptr) else $error("pointer read outside page zero");

	property p_short_direct;
		@(posedge sys_clk) disable iff (sys_rst)
		(done && mode_reg == OAG_SHORT_DIRECT) |-> (ea_reg[15:8] == 8'h00);
	endproperty
	a_short_direct: assert property (p_short_direct) else $error("short direct left page zero");

	sequence s_two_fetches;
		prog_req ##2 prog_req;
	endsequence
	property p_long_direct;
		@(posedge sys_clk) disable iff (sys_rst)
		(start && !illegal_mode && state_reg == OAG_ST_IDLE && mode == OAG_LONG_DIRECT) |=> s_two_fetches ##2 done;
	endproperty
	a_long_direct: assert property (p_long_direct) else $error("long direct did not fetch two bytes");

	property p_no_offset;
		@(posedge sys_clk) disable iff (sys_rst)
		(start && state_reg == OAG_ST_IDLE && mode == OAG_IDX_NO_OFS) |=> done && !prog_req ##1 (ea_reg == {8'h00, $past(index_value, 2)});
	endproperty
	a_no_offset: assert property (p_no_offset) else $error("no-offset indexed address wrong");

	property p_index_range;
		@(posedge sys_clk) disable iff (sys_rst)
		(done && mode_reg == OAG_IDX_SHORT) |-> (ea_reg <= 16'h01FE);
	endproperty
	a_index_range: assert property (p_index_range) else $error("short indexed beyond 01FE");

	property p_rel_range;
		@(posedge sys_clk) disable iff (sys_rst)
		(done && mode_reg == OAG_REL_DIRECT) |-> (branch_target_reg - next_pc_reg + 16'h0080 <= 16'h00FF);
	endproperty
	a_rel_range: assert property (p_rel_range) else $error("relative target out of range");

	property p_word_ptr;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_reg == OAG_ST_PTR_LO && pend_ptr_reg && word_reg) |=> (state_reg == OAG_ST_PTR_HI && data_req);
	endproperty
	a_word_ptr: assert property (p_word_ptr) else $error("word pointer high byte not read");

	property p_bit_page;
		@(posedge sys_clk) disable iff (sys_rst)
		(done && (mode_reg == OAG_BIT_DIRECT || mode_reg == OAG_BIT_INDIRECT)) |-> (ea_reg[15:8] == 8'h00);
	endproperty
	a_bit_page: assert property (p_bit_page) else $error("bit operand outside page zero");

endmodule

// ### src/oag_pkg.sv
/*
 Constants shared by the operand address generator: addressing modes,
 the mode count, page and reset values and the sequencer states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package oag_pkg;

	typedef enum logic [4:0] {
		OAG_INHERENT,
		OAG_IMMEDIATE,
		OAG_SHORT_DIRECT,
		OAG_LONG_DIRECT,
		OAG_IDX_NO_OFS,
		OAG_IDX_SHORT,
		OAG_IDX_LONG,
		OAG_IND_SHORT,
		OAG_IND_LONG,
		OAG_IND_IDX_SHORT,
		OAG_IND_IDX_LONG,
		OAG_REL_DIRECT,
		OAG_REL_INDIRECT,
		OAG_BIT_DIRECT,
		OAG_BIT_INDIRECT,
		OAG_BIT_DIRECT_REL,
		OAG_BIT_INDIRECT_REL
	} oag_mode_type;

	localparam int unsigned OAG_MODE_COUNT = 17;
	localparam logic [7:0]  OAG_PAGE_ZERO_HI = 8'h00;
	localparam logic [15:0] OAG_ADDR_RESET = 16'h0000;
	localparam logic [7:0]  OAG_BYTE_RESET = 8'h00;

	typedef enum logic [3:0] {
		OAG_ST_IDLE,
		OAG_ST_FETCH,
		OAG_ST_PTR_LO,
		OAG_ST_PTR_HI,
		OAG_ST_DONE
	} oag_state_type;

endpackage

// ### src/oag_mode_table.sv
/*
 Mode table: extra instruction bytes and pointer needs per addressing mode.
 Assumes a legal mode code from the opcode decoder.
*/
`timescale 1ns/1ps
module oag_mode_table
	import oag_pkg::*;
(
	input  wire oag_mode_type mode,
	output logic [1:0]        operand_bytes,
	output logic              uses_pointer,
	output logic              word_pointer,
	output logic              is_short_form
);

	always_comb begin
		operand_bytes = 2'd0;
		uses_pointer  = 1'b0;
		word_pointer  = 1'b0;
		is_short_form = 1'b1;
		unique case (mode)
			OAG_INHERENT, OAG_IDX_NO_OFS: begin
				operand_bytes = 2'd0;
			end
			OAG_IMMEDIATE, OAG_SHORT_DIRECT, OAG_IDX_SHORT, OAG_REL_DIRECT, OAG_BIT_DIRECT: begin
				operand_bytes = 2'd1;
			end
			OAG_LONG_DIRECT, OAG_IDX_LONG: begin
				operand_bytes = 2'd2;
				is_short_form = 1'b0;
			end
			OAG_IND_SHORT, OAG_IND_IDX_SHORT, OAG_REL_INDIRECT, OAG_BIT_INDIRECT: begin
				operand_bytes = 2'd1;
				uses_pointer  = 1'b1;
			end
			OAG_IND_LONG, OAG_IND_IDX_LONG: begin
				operand_bytes = 2'd1;
				uses_pointer  = 1'b1;
				word_pointer  = 1'b1;
				is_short_form = 1'b0;
			end
			OAG_BIT_DIRECT_REL: begin
				operand_bytes = 2'd2;
			end
			OAG_BIT_INDIRECT_REL: begin
				operand_bytes = 2'd2;
				uses_pointer  = 1'b1;
			end
			default: begin
				operand_bytes = 2'd0;
			end
		endcase
	end

endmodule

// ### tb/oag_mem_model.sv
/*
 Program and data memory seen by the operand address generator.
 Assumes requests answered one cycle later; bench fills the arrays.
*/
`timescale 1ns/1ps
module oag_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        prog_req,
	input  wire logic [15:0] prog_addr,
	output logic      [7:0]  prog_data,
	input  wire logic        data_req,
	input  wire logic [15:0] data_addr,
	output logic      [7:0]  data_data
);
	logic [7:0] pmem [0:65535];
	logic [7:0] dmem [0:65535];

	initial begin
		prog_data = 8'h00;
		data_data = 8'h00;
	end

	// Released bus flips so stale bytes never pass for data
	always @(posedge sys_clk) begin
		prog_data <= prog_req ? pmem[prog_addr] : ~prog_data;
		data_data <= data_req ? dmem[data_addr] : ~data_data;
	end
endmodule

// ### tb/oag_core_tb_top.sv
/*
 Self-checking bench of the operand address generator.
 Assumes the one-cycle memory model and the package mode order.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module oag_core_tb_top
	import oag_pkg::*;
;
	logic         sys_clk, sys_rst, start, rmw_op, prog_req, data_req;
	logic         busy, done, illegal_mode;
	oag_mode_type mode;
	logic [7:0]   index_value, prog_data, data_data, imm_reg;
	logic [2:0]   bit_select, bit_pos_reg;
	logic [15:0]  operand_pc, prog_addr, data_addr, ea_reg, branch_target_reg, next_pc_reg;
	logic [1:0]   extra_bytes_reg;
	int           bad_count, checked, cycles;

	oag_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .mode(mode), .rmw_op(rmw_op),
		.index_value(index_value), .bit_select(bit_select), .operand_pc(operand_pc),
		.prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data), .data_req(data_req),
		.data_addr(data_addr), .data_data(data_data), .busy(busy), .done(done),
		.illegal_mode(illegal_mode), .ea_reg(ea_reg), .imm_reg(imm_reg), .bit_pos_reg(bit_pos_reg),
		.branch_target_reg(branch_target_reg), .next_pc_reg(next_pc_reg),
		.extra_bytes_reg(extra_bytes_reg));

	oag_mem_model mem (.sys_clk(sys_clk), .prog_req(prog_req), .prog_addr(prog_addr),
		.prog_data(prog_data), .data_req(data_req), .data_addr(data_addr), .data_data(data_data));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic setp(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1);
		mem.pmem[a] = b0;
		mem.pmem[a + 16'h0001] = b1;
	endtask

	task automatic op(input oag_mode_type m, input logic r, input logic [7:0] ix,
		input logic [2:0] bs, input logic [15:0] pc);
		int n;
		@(negedge sys_clk);
		mode = m;
		rmw_op = r;
		index_value = ix;
		bit_select = bs;
		operand_pc = pc;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(done, 1'b1)
	endtask

	task automatic t_all_modes();
		logic [1:0] exb [17];
		exb = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2,
			2'h1, 2'h2, 2'h2, 2'h3};
		// Known bytes so every mode forms a defined address
		setp(16'h4000, 8'h10, 8'h02);
		mem.dmem[16'h0010] = 8'h30;
		mem.dmem[16'h0011] = 8'h40;
		for (int i = 0; i < OAG_MODE_COUNT; i++) begin
			op(oag_mode_type'(i), 1'b0, 8'h01, 3'h0, 16'h4000);
			`CHK(extra_bytes_reg, exb[i])
		end
		$display("t_all_modes done");
	endtask

	task automatic t_direct();
		setp(16'h1234, 8'hAB, 8'hCD);
		op(OAG_LONG_DIRECT, 1'b0, 8'h00, 3'h0, 16'h1234);
		`CHK(ea_reg, 16'hABCD)
		setp(16'h0100, 8'h80, 8'h00);
		op(OAG_SHORT_DIRECT, 1'b0, 8'h00, 3'h0, 16'h0100);
		`CHK(ea_reg, 16'h0080)
		op(OAG_IMMEDIATE, 1'b0, 8'h00, 3'h0, 16'h0100);
		`CHK(imm_reg, 8'h80)
		$display("t_direct done");
	endtask

	task automatic t_indexed();
		op(OAG_IDX_NO_OFS, 1'b0, 8'hFF, 3'h0, 16'h0100);
		`CHK(ea_reg, 16'h00FF)
		setp(16'h0200, 8'hFF, 8'h00);
		op(OAG_IDX_SHORT, 1'b0, 8'hFF, 3'h0, 16'h0200);
		`CHK(ea_reg, 16'h01FE)
		setp(16'h0300, 8'h10, 8'h00);
		op(OAG_IDX_LONG, 1'b0, 8'h10, 3'h0, 16'h0300);
		`CHK(ea_reg, 16'h1010)
		$display("t_indexed done");
	endtask

	task automatic t_indirect();
		setp(16'h0400, 8'hF0, 8'h00);
		mem.dmem[16'h00F0] = 8'h20;
		mem.dmem[16'h00F1] = 8'h34;
		op(OAG_IND_SHORT, 1'b0, 8'h00, 3'h0, 16'h0400);
		`CHK(ea_reg, 16'h0020)
		op(OAG_IND_LONG, 1'b0, 8'h00, 3'h0, 16'h0400);
		`CHK(ea_reg, 16'h2034)
		op(OAG_IND_IDX_SHORT, 1'b0, 8'hF0, 3'h0, 16'h0400);
		`CHK(ea_reg, 16'h0110)
		op(OAG_IND_IDX_LONG, 1'b0, 8'hF0, 3'h0, 16'h0400);
		`CHK(ea_reg, 16'h2124)
		$display("t_indirect done");
	endtask

	task automatic t_relative();
		setp(16'h2000, 8'h81, 8'h00);
		op(OAG_REL_DIRECT, 1'b0, 8'h00, 3'h0, 16'h2000);
		`CHK(branch_target_reg, 16'h1F82)
		`CHK(next_pc_reg, 16'h2001)
		setp(16'h3000, 8'h20, 8'h00);
		mem.dmem[16'h0020] = 8'h7F;
		op(OAG_REL_INDIRECT, 1'b0, 8'h00, 3'h0, 16'h3000);
		`CHK(branch_target_reg, 16'h3080)
		$display("t_relative done");
	endtask

	task automatic t_bits();
		setp(16'h5000, 8'h55, 8'h83);
		mem.dmem[16'h0055] = 8'h66;
		op(OAG_BIT_DIRECT, 1'b0, 8'h00, 3'h7, 16'h5000);
		`CHK(ea_reg, 16'h0055)
		`CHK(bit_pos_reg, 3'h7)
		op(OAG_BIT_INDIRECT, 1'b0, 8'h00, 3'h0, 16'h5000);
		`CHK(ea_reg, 16'h0066)
		`CHK(bit_pos_reg, 3'h0)
		op(OAG_BIT_DIRECT_REL, 1'b0, 8'h00, 3'h3, 16'h5000);
		`CHK(branch_target_reg, 16'h4F85)
		op(OAG_BIT_INDIRECT_REL, 1'b0, 8'h00, 3'h3, 16'h5000);
		`CHK(ea_reg, 16'h0066)
		`CHK(branch_target_reg, 16'h4F85)
		$display("t_bits done");
	endtask

	task automatic t_rmw();
		oag_mode_type lm [4];
		logic [15:0]  old;
		lm = '{OAG_LONG_DIRECT, OAG_IDX_LONG, OAG_IND_LONG, OAG_IND_IDX_LONG};
		old = ea_reg;
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk);
			mode = lm[i];
			rmw_op = 1'b1;
			start = 1'b1;
			#1;
			`CHK(illegal_mode, 1'b1)
			@(negedge sys_clk);
			start = 1'b0;
			`CHK(busy, 1'b0)
			`CHK(ea_reg, old)
		end
		op(OAG_SHORT_DIRECT, 1'b1, 8'h00, 3'h0, 16'h0100);
		`CHK(ea_reg, 16'h0080)
		$display("t_rmw done");
	endtask

	initial begin
		bad_count = 0;
		checked = 0;
		cycles = 0;
		sys_rst = 1'b1;
		start = 1'b0;
		mode = OAG_INHERENT;
		rmw_op = 1'b0;
		index_value = 8'h00;
		bit_select = 3'h0;
		operand_pc = 16'h0000;
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_all_modes();
		t_direct();
		t_indexed();
		t_indirect();
		t_relative();
		t_bits();
		t_rmw();
		wrap_up();
	end
endmodule
